// [tvu_trip_vote.sv]
module tvu_trip_vote #(
    parameter int HALF = tvu_pkg::HALF_CYC,
    parameter int STALE_CYC = tvu_pkg::STALE_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic [tvu_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // trip links from the four channels and the neutron monitor
    input wire logic [tvu_pkg::NUM_CH-1:0] divisional_trip_channel,
    input wire logic neutron_monitor_trips,
    // panel jumpers
    input wire logic [1:0] chan_jumper,
    // bypass unit switches
    input wire logic byp_sensor,
    input wire logic [1:0] byp_sensor_sel,
    input wire logic byp_logic,
    input wire logic byp_steam_iso,
    input wire logic byp_transient,
    // load driver switches, one line out and one back each
    output logic [3:0] ld_scram_cmd,
    input wire logic [3:0] ld_scram_ret,
    output logic [3:0] ld_iso_cmd,
    input wire logic [3:0] ld_iso_ret,
    output logic backup_scram_trip,
    output logic scram_cmd,
    output logic iso_cmd,
    output logic [15:0] comms_gateway
);
    import tvu_pkg::*;

    localparam int NL = NUM_CH + 1;

    generate
        if (STALE_CYC < 1 || HALF < 2) begin : g_bad_param
            $error("tvu_trip_vote: STALE_CYC must be >= 1 and HALF >= 2");
        end
    endgenerate

    // ==================================================
    // helpers
    function automatic logic vote_2oo4(input logic [3:0] trips, input logic excl_en, input logic [1:0] excl_sel);
        logic [3:0] used;
        logic [2:0] n;
        used = trips;
        n = 3'h0;
        if (excl_en) begin
            used[excl_sel] = 1'b0;
        end
        for (int i = 0; i < 4; i++) begin
            n = n + {2'h0, used[i]};
        end
        return n >= 3'(VOTE_MIN);
    endfunction : vote_2oo4

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        return a == off;
    endfunction : hit

    // ==================================================
    // link receivers, one per source
    tvu_trip_if links [NL] ();
    logic [NL-1:0] line_all;
    logic [NL-1:0] scram_in, iso_in, stale_in, bad_in;

    assign line_all = {neutron_monitor_trips, divisional_trip_channel};

    genvar g;
    generate
        for (g = 0; g < NL; g++) begin : g_rx
            tvu_link_rx #(
                .HALF(HALF),
                .STALE(STALE_CYC)
            ) u_rx (
                .pclk(pclk),
                .presetn(presetn),
                .line_in(line_all[g]),
                .link(links[g])
            );
            assign scram_in[g] = links[g].scram_trip;
            assign iso_in[g] = links[g].iso_trip;
            assign stale_in[g] = links[g].stale;
            assign bad_in[g] = links[g].bad;
        end
    endgenerate

    // ==================================================
    // synchronisers for jumpers, bypass switches and driver returns
    logic [1:0] jmp1, jmp2;
    logic [5:0] byp1, byp2;
    logic [7:0] ret1, ret2;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            jmp1 <= 2'h0;
            jmp2 <= 2'h0;
            byp1 <= 6'h00;
            byp2 <= 6'h00;
            ret1 <= 8'h00;
            ret2 <= 8'h00;
        end else begin
            jmp1 <= chan_jumper;
            jmp2 <= jmp1;
            byp1 <= {byp_transient, byp_steam_iso, byp_logic, byp_sensor_sel, byp_sensor};
            byp2 <= byp1;
            ret1 <= {ld_iso_ret, ld_scram_ret};
            ret2 <= ret1;
        end
    end

    logic b_sensor, b_logic, b_steam, b_trans;
    logic [1:0] b_sel;
    assign b_sensor = byp2[0];
    assign b_sel = byp2[2:1];
    assign b_logic = byp2[3];
    assign b_steam = byp2[4];
    assign b_trans = byp2[5];

    // ==================================================
    // channel number, caught once after reset release
    logic [1:0] settle;
    logic [1:0] chan_id;
    logic chan_valid;

    // wait for the synchroniser to fill before trusting the jumpers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle <= 2'h0;
            chan_id <= 2'h0;
            chan_valid <= 1'b0;
        end else if (!chan_valid) begin
            if (settle == 2'(JUMP_SETTLE - 1)) begin
                chan_id <= jmp2;
                chan_valid <= 1'b1;
            end else begin
                settle <= settle + 1'b1;
            end
        end
    end

    // ==================================================
    // control register; only adds trips, so software can never mask one
    logic [1:0] ctrl;

    // ==================================================
    // vote and command stage
    logic vote_scram, vote_iso;
    logic next_scram, next_iso;

    assign vote_scram = vote_2oo4(scram_in[NUM_CH-1:0], b_sensor, b_sel);
    // isolation vote ignores the sensor bypass; steam-line bypass holds off the voted isolation
    assign vote_iso = vote_2oo4(iso_in[NUM_CH-1:0], 1'b0, 2'h0) & !b_steam;
    assign next_scram = vote_scram | scram_in[NUM_CH] | ctrl[CTRL_FORCE_SCRAM];
    assign next_iso = vote_iso | ctrl[CTRL_FORCE_ISO];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scram_cmd <= 1'b0;
            iso_cmd <= 1'b0;
        end else begin
            scram_cmd <= next_scram;
            iso_cmd <= next_iso;
        end
    end

    // ==================================================
    // output logic: load drivers de-energize to trip, backup line is raised to trip, all held tripped in reset
    logic scram_eff, iso_eff;
    assign scram_eff = scram_cmd & !b_logic;
    assign iso_eff = iso_cmd & !b_logic;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ld_scram_cmd <= 4'h0;
            ld_iso_cmd <= 4'h0;
            backup_scram_trip <= 1'b1;
        end else begin
            ld_scram_cmd <= {4{!scram_eff}};
            ld_iso_cmd <= {4{!iso_eff}};
            backup_scram_trip <= scram_eff;
        end
    end

    // driver self-test: returned state must follow the command
    logic ld_scram_flt, ld_iso_flt;
    assign ld_scram_flt = |(ret2[3:0] ^ ld_scram_cmd);
    assign ld_iso_flt = |(ret2[7:4] ^ ld_iso_cmd);

    // status word toward the comms gateway
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            comms_gateway <= 16'h0000;
        end else begin
            comms_gateway <= {chan_valid, chan_id, b_trans, b_steam, b_logic, b_sensor,
                ld_iso_flt, ld_scram_flt, backup_scram_trip, iso_eff, scram_eff, |bad_in, |stale_in,
                iso_cmd, scram_cmd};
        end
    end

    // ==================================================
    // apb slave: one wait state, pready from a flop
    logic access, wr_fire;
    logic known;
    logic [31:0] rd_word;

    assign access = psel & penable & !pready;
    assign wr_fire = psel & penable & pready & pwrite;
    assign known = hit(paddr, OFF_STATUS) | hit(paddr, OFF_CTRL) | hit(paddr, OFF_FAULT) | hit(paddr, OFF_CHAN);

    // read mux, unmapped reads as zero
    always_comb begin
        rd_word = 32'h0000_0000;
        if (hit(paddr, OFF_STATUS)) begin
            rd_word[ST_CH_SCRAM +: NUM_CH] = scram_in[NUM_CH-1:0];
            rd_word[ST_CH_ISO +: NUM_CH] = iso_in[NUM_CH-1:0];
            rd_word[ST_NM] = scram_in[NUM_CH];
            rd_word[ST_SCRAM] = scram_cmd;
            rd_word[ST_ISO] = iso_cmd;
            rd_word[ST_BACKUP] = backup_scram_trip;
            rd_word[ST_BYP +: 4] = {b_trans, b_steam, b_logic, b_sensor};
            rd_word[ST_BYP_SEL +: 2] = b_sel;
            rd_word[ST_LD_SCRAM_FLT] = ld_scram_flt;
            rd_word[ST_LD_ISO_FLT] = ld_iso_flt;
        end else if (hit(paddr, OFF_CTRL)) begin
            rd_word[1:0] = ctrl;
        end else if (hit(paddr, OFF_FAULT)) begin
            rd_word[FLT_STALE +: NL] = stale_in;
            rd_word[FLT_BAD +: NL] = bad_in;
        end else if (hit(paddr, OFF_CHAN)) begin
            rd_word[1:0] = chan_id;
            rd_word[CHAN_VALID] = chan_valid;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= access;
            pslverr <= access & !known;
            prdata <= (access && !pwrite) ? rd_word : 32'h0000_0000;
        end
    end

    // control write at the completing edge only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CTRL_RESET;
        end else if (wr_fire && hit(paddr, OFF_CTRL)) begin
            ctrl <= pwdata[1:0];
        end
    end
endmodule : tvu_trip_vote

// [tvu_pkg.sv]
package tvu_pkg;
    // ==================================================
    // clock and timing
    localparam int CLK_MHZ = 125;
    localparam int STALE_US = 1000;
    localparam int STALE_CYC = STALE_US * CLK_MHZ;
    localparam int HALF_CYC = 4;
    localparam int JUMP_SETTLE = 3;
    localparam int NUM_CH = 4;
    localparam int VOTE_MIN = 2;

    // ==================================================
    // trip frame layout: start, scram, isolation, odd parity
    localparam int FRAME_BITS = 4;
    localparam int FR_START = 3;
    localparam int FR_SCRAM = 2;
    localparam int FR_ISO = 1;

    // ==================================================
    // apb register map
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_CTRL = 8'h04;
    localparam logic [7:0] OFF_FAULT = 8'h08;
    localparam logic [7:0] OFF_CHAN = 8'h0C;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam int CTRL_FORCE_SCRAM = 0;
    localparam int CTRL_FORCE_ISO = 1;
    localparam int ST_CH_SCRAM = 0;
    localparam int ST_CH_ISO = 4;
    localparam int ST_NM = 8;
    localparam int ST_SCRAM = 9;
    localparam int ST_ISO = 10;
    localparam int ST_BACKUP = 11;
    localparam int ST_BYP = 12;
    localparam int ST_BYP_SEL = 16;
    localparam int ST_LD_SCRAM_FLT = 18;
    localparam int ST_LD_ISO_FLT = 19;
    localparam int FLT_STALE = 0;
    localparam int FLT_BAD = 8;
    localparam int CHAN_VALID = 8;

    typedef enum logic [0:0] {
        TVU_RX_IDLE = 1'b0,
        TVU_RX_BITS = 1'b1
    } tvu_rx_state_e;
endpackage : tvu_pkg

// [tvu_trip_if.sv]
// ==================================================
// decoded trip input from one link receiver
interface tvu_trip_if;
    logic scram_trip;
    logic iso_trip;
    logic stale;
    logic bad;
    modport rx (output scram_trip, output iso_trip, output stale, output bad);
    modport vote (input scram_trip, input iso_trip, input stale, input bad);
endinterface : tvu_trip_if

// [tvu_link_rx.sv]
module tvu_link_rx #(
    parameter int HALF = tvu_pkg::HALF_CYC,
    parameter int STALE = tvu_pkg::STALE_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic line_in,
    tvu_trip_if.rx link
);
    import tvu_pkg::*;

    localparam int CW = $clog2(2 * HALF);
    localparam int SW = $clog2(STALE + 1);
    localparam logic [CW-1:0] MID1 = CW'(HALF / 2);
    localparam logic [CW-1:0] MID2 = CW'(HALF + HALF / 2);
    localparam logic [CW-1:0] LAST = CW'(2 * HALF - 1);
    localparam logic [1:0] LAST_BIT = 2'(FRAME_BITS - 1);
    localparam logic [SW-1:0] STALE_MAX = SW'(STALE);

    generate
        if (HALF < 2 || STALE < 1) begin : g_bad_param
            $error("tvu_link_rx: HALF must be >= 2 and STALE >= 1");
        end
    endgenerate

    logic s1, s2, s3;
    tvu_rx_state_e state;
    logic [CW-1:0] cnt;
    logic [1:0] bidx;
    logic first_half;
    logic err;
    logic [FRAME_BITS-1:0] sreg;
    logic [SW-1:0] age;
    logic scram_q, iso_q, bad_q;
    logic frame_end;
    logic [FRAME_BITS-1:0] full;
    logic good;

    // ==================================================
    // pin synchroniser; s1 feeds s2 only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end else begin
            s1 <= line_in;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // frame check at the last mid-bit sample
    assign frame_end = (state == TVU_RX_BITS) && (cnt == MID2) && (bidx == LAST_BIT);
    assign full = {sreg[FRAME_BITS-2:0], first_half};
    assign good = !err && (first_half != s2) && full[FR_START] && (^full);

    // ==================================================
    // manchester bit walker, started by a rising edge when idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= TVU_RX_IDLE;
            cnt <= '0;
            bidx <= 2'h0;
            first_half <= 1'b0;
            err <= 1'b0;
            sreg <= '0;
        end else begin
            case (state)
                TVU_RX_IDLE: begin
                    if (s2 && !s3) begin
                        state <= TVU_RX_BITS;
                        cnt <= '0;
                        bidx <= 2'h0;
                        err <= 1'b0;
                    end
                end
                TVU_RX_BITS: begin
                    cnt <= cnt + 1'b1;
                    if (cnt == MID1) begin
                        first_half <= s2;
                    end
                    if (cnt == MID2) begin
                        sreg <= full;
                        // both halves equal: no mid-bit transition
                        if (first_half == s2) begin
                            err <= 1'b1;
                        end
                    end
                    if (cnt == LAST) begin
                        cnt <= '0;
                        bidx <= bidx + 1'b1;
                        if (bidx == LAST_BIT) begin
                            state <= TVU_RX_IDLE;
                        end
                    end
                end
                default: state <= TVU_RX_IDLE;
            endcase
        end
    end

    // ==================================================
    // decoded result; reset reads as tripped until a good frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scram_q <= 1'b1;
            iso_q <= 1'b1;
            bad_q <= 1'b0;
        end else if (frame_end) begin
            if (good) begin
                scram_q <= full[FR_SCRAM];
                iso_q <= full[FR_ISO];
                bad_q <= 1'b0;
            end else begin
                bad_q <= 1'b1;
            end
        end
    end

    // refresh watchdog, starts expired so silence is a trip
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            age <= STALE_MAX;
        end else if (frame_end && good) begin
            age <= '0;
        end else if (age != STALE_MAX) begin
            age <= age + 1'b1;
        end
    end

    assign link.stale = (age == STALE_MAX);
    assign link.bad = bad_q;
    assign link.scram_trip = scram_q | bad_q | link.stale;
    assign link.iso_trip = iso_q | bad_q | link.stale;
endmodule : tvu_link_rx

// [tvu_trip_vote_chk.sv]
module tvu_trip_vote_chk #(
    parameter int STALE_CYC = 200
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [tvu_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic neutron_monitor_trips,
    input wire logic byp_logic,
    input wire logic [3:0] ld_scram_cmd,
    input wire logic [3:0] ld_iso_cmd,
    input wire logic backup_scram_trip,
    input wire logic scram_cmd,
    input wire logic iso_cmd,
    input wire logic [15:0] comms_gateway
);
    timeunit 1ns;
    timeprecision 1ps;
    import tvu_pkg::*;
    int nm_quiet;

    // ====
    // silent neutron link counter, saturating so it never wraps
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nm_quiet <= 0;
        end else if (neutron_monitor_trips) begin
            nm_quiet <= 0;
        end else if (nm_quiet < STALE_CYC + 64) begin
            nm_quiet <= nm_quiet + 1;
        end
    end

    // ====
    // properties
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    AST_LD_SCRAM: assert property (!byp_logic [*4] |=> ld_scram_cmd == {4{!$past(scram_cmd)}})
        else $error("scram drivers not following the command");
    AST_LD_ISO: assert property (!byp_logic [*4] |=> ld_iso_cmd == {4{!$past(iso_cmd)}})
        else $error("isolation drivers not following the command");
    AST_BACKUP: assert property (!byp_logic [*4] |=> backup_scram_trip == $past(scram_cmd))
        else $error("backup path not following the scram command");
    AST_LOGIC_BYP: assert property (byp_logic [*4] |-> ld_scram_cmd == 4'hF && ld_iso_cmd == 4'hF)
        else $error("logic bypass not holding drivers energized");
    AST_STALE: assert property (nm_quiet >= STALE_CYC + 32 |-> scram_cmd)
        else $error("silent neutron link did not trip");
    AST_CHAN_HOLD: assert property (comms_gateway[15] && $past(comms_gateway[15]) |-> $stable(comms_gateway[14:13]))
        else $error("channel id changed after capture");
    AST_PREADY_ONE: assert property (psel && penable && !pready |=> pready)
        else $error("bus answer late");
    AST_PREADY_PULSE: assert property (pready |=> !pready)
        else $error("bus ready longer than one cycle");
    AST_ERR_UNMAPPED: assert property (pready && paddr > 8'h0C |-> pslverr)
        else $error("unmapped access without error");
endmodule : tvu_trip_vote_chk

bind tvu_trip_vote tvu_trip_vote_chk #(.STALE_CYC(STALE_CYC)) u_chk (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .neutron_monitor_trips(neutron_monitor_trips),
    .byp_logic(byp_logic), .ld_scram_cmd(ld_scram_cmd), .ld_iso_cmd(ld_iso_cmd),
    .backup_scram_trip(backup_scram_trip), .scram_cmd(scram_cmd), .iso_cmd(iso_cmd),
    .comms_gateway(comms_gateway)
);

// [tvu_chan_model.sv]
module tvu_chan_model #(
    parameter int HALF = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [4:0] scram_bits,
    input wire logic [4:0] iso_bits,
    input wire logic [4:0] bad,
    input wire logic [4:0] mute,
    input wire logic ld_fault,
    input wire logic [3:0] ld_scram_cmd,
    input wire logic [3:0] ld_iso_cmd,
    output logic [4:0] links,
    output logic [3:0] ld_scram_ret,
    output logic [3:0] ld_iso_ret
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PER = 8 * HALF + 8;
    int cnt;
    logic [4:0] fr [5];

    // ====
    // frame timer; bits latched at frame start so a link never mixes patterns
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 0;
            for (int k = 0; k < 5; k++) begin
                fr[k] <= 5'h08;
            end
        end else begin
            cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
            if (cnt == PER - 1) begin
                for (int k = 0; k < 5; k++) begin
                    fr[k] <= {mute[k], 1'b1, scram_bits[k], iso_bits[k], scram_bits[k] ^ iso_bits[k] ^ bad[k]};
                end
            end
        end
    end

    // manchester line, low between frames and while muted
    always_comb begin
        for (int k = 0; k < 5; k++) begin
            links[k] = 1'b0;
            if (cnt < 8 * HALF && !fr[k][4]) begin
                links[k] = fr[k][3 - cnt / (2 * HALF)] ^ (cnt % (2 * HALF) >= HALF);
            end
        end
    end

    // driver self-test echo; fault flips one switch to fake a bad return
    assign ld_scram_ret = ld_scram_cmd ^ {3'h0, ld_fault};
    assign ld_iso_ret = ld_iso_cmd;
endmodule : tvu_chan_model

// [tb.sv]
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import tvu_pkg::*;
    localparam int WAIT = 100;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, backup_scram_trip, scram_cmd, iso_cmd;
    logic [4:0] ch_s = 5'h0, ch_i = 5'h0, ch_bad = 5'h0, ch_mute = 5'h0, links;
    logic ld_flt = 1'b0, byp_s = 1'b0, byp_l = 1'b0, byp_st = 1'b0, byp_tr = 1'b0;
    logic [1:0] byp_sel = 2'h0, jumper = 2'h2;
    logic [3:0] ld_scram_cmd, ld_iso_cmd, ld_scram_ret, ld_iso_ret;
    logic [15:0] comms_gateway;
    int num_errors = 0, num_checks = 0, cyc = 0;

    // ====
    // clock, design and far side
    initial forever #4 pclk = ~pclk;
    tvu_trip_vote #(.HALF(4), .STALE_CYC(200)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .divisional_trip_channel(links[3:0]), .neutron_monitor_trips(links[4]),
        .chan_jumper(jumper), .byp_sensor(byp_s), .byp_sensor_sel(byp_sel), .byp_logic(byp_l),
        .byp_steam_iso(byp_st), .byp_transient(byp_tr), .ld_scram_cmd(ld_scram_cmd),
        .ld_scram_ret(ld_scram_ret), .ld_iso_cmd(ld_iso_cmd), .ld_iso_ret(ld_iso_ret),
        .backup_scram_trip(backup_scram_trip), .scram_cmd(scram_cmd), .iso_cmd(iso_cmd),
        .comms_gateway(comms_gateway));
    tvu_chan_model #(.HALF(4)) far (.pclk(pclk), .presetn(presetn), .scram_bits(ch_s), .iso_bits(ch_i),
        .bad(ch_bad), .mute(ch_mute), .ld_fault(ld_flt), .ld_scram_cmd(ld_scram_cmd),
        .ld_iso_cmd(ld_iso_cmd), .links(links), .ld_scram_ret(ld_scram_ret), .ld_iso_ret(ld_iso_ret));

    // ====
    // shared tasks
    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : check

    // one bus cycle; request held until ready is sampled high
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q,
        output logic e);
        int n;
        n = 0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge pclk);
        penable <= 1'b1;
        // no local limit here; a dead slave is caught by the run timeout
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        // one wait state: ready is seen at the second access edge
        check("bus answer", 32'h2, n);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp, input string nm);
        logic [31:0] q;
        logic e;
        apb(a, 1'b0, 32'h0, q, e);
        check(nm, exp, q & m);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(a, 1'b1, d, q, e);
    endtask : wr

    // let new frames land first, since the old commands may match only for now,
    // then wait for the commands (stale needs longer) and let them rest before judging
    task automatic settle(input logic s, input logic i, input string nm);
        int n;
        n = 0;
        repeat (WAIT) @(posedge pclk);
        while ({scram_cmd, iso_cmd} !== {s, i} && n < 500) begin
            @(posedge pclk);
            n++;
        end
        repeat (WAIT) @(posedge pclk);
        check({nm, " cmd"}, {30'h0, s, i}, {30'h0, scram_cmd, iso_cmd});
        check({nm, " out"}, {23'h0, !byp_l && s, byp_l ? 8'hFF : {{4{!s}}, {4{!i}}}},
            {23'h0, backup_scram_trip, ld_scram_cmd, ld_iso_cmd});
        check({nm, " gw"}, {30'h0, i, s}, {30'h0, comms_gateway[1:0]});
    endtask : settle

    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done

    // ====
    // scenarios
    task automatic t_regs;
        logic [31:0] q;
        logic e;
        rd(OFF_CHAN, 32'h1FF, 32'h102, "channel id");
        rd(OFF_CTRL, 32'hFFFFFFFF, 32'h0, "ctrl reset");
        apb(8'h10, 1'b0, 32'h0, q, e);
        check("unmapped error", 32'h1, {31'h0, e});
        $display("test regs done");
    endtask : t_regs

    task automatic t_vote;
        for (int p = 0; p < 16; p++) begin
            ch_s <= {1'b0, p[3:0]};
            ch_i <= {1'b0, ~p[3:0]};
            settle($countones(p[3:0]) >= 2, $countones(~p[3:0]) >= 2, "vote");
        end
        $display("test vote done");
    endtask : t_vote

    // the excluded channel plus one other must not trip; two others must
    task automatic t_bypass;
        byp_s <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            byp_sel <= k[1:0];
            ch_s <= (5'h1 << k) | (5'h1 << ((k + 1) % 4));
            ch_i <= (5'h1 << k) | (5'h1 << ((k + 1) % 4));
            settle(1'b0, 1'b1, "sensor bypass one left");
            ch_s <= (5'h1 << ((k + 1) % 4)) | (5'h1 << ((k + 2) % 4));
            settle(1'b1, 1'b1, "sensor bypass two left");
        end
        byp_s <= 1'b0;
        byp_st <= 1'b1;
        settle(1'b1, 1'b0, "steam bypass");
        byp_st <= 1'b0;
        $display("test bypass done");
    endtask : t_bypass

    task automatic t_faults;
        ch_s <= 5'h2;
        ch_i <= 5'h2;
        ch_bad <= 5'h1;
        settle(1'b1, 1'b1, "bad frame");
        rd(OFF_FAULT, 32'h1F1F, 32'h100, "bad flag");
        ch_bad <= 5'h0;
        ch_mute <= 5'h4;
        settle(1'b1, 1'b1, "stale link");
        rd(OFF_FAULT, 32'h1F1F, 32'h4, "stale flag");
        ch_mute <= 5'h0;
        ch_s <= 5'h10;
        ch_i <= 5'h0;
        settle(1'b1, 1'b0, "neutron trip");
        ch_s <= 5'h0;
        settle(1'b0, 1'b0, "neutron clear");
        // muted after a clean frame, so only the watchdog can raise scram
        ch_mute <= 5'h10;
        settle(1'b1, 1'b0, "neutron stale");
        ch_mute <= 5'h0;
        settle(1'b0, 1'b0, "all clear");
        $display("test faults done");
    endtask : t_faults

    task automatic t_force;
        wr(OFF_CTRL, 32'h1);
        settle(1'b1, 1'b0, "force scram");
        wr(OFF_CTRL, 32'h2);
        settle(1'b0, 1'b1, "force iso");
        rd(OFF_CTRL, 32'hFFFFFFFF, 32'h2, "ctrl readback");
        wr(OFF_CTRL, 32'h0);
        ld_flt <= 1'b1;
        settle(1'b0, 1'b0, "force off");
        rd(OFF_STATUS, 32'hC0000, 32'h40000, "driver return");
        ld_flt <= 1'b0;
        $display("test force done");
    endtask : t_force

    task automatic t_logic;
        {byp_l, byp_tr, byp_s, byp_st} <= 4'hF;
        byp_sel <= 2'h3;
        ch_s <= 5'h3;
        ch_i <= 5'h3;
        settle(1'b1, 1'b0, "logic bypass");
        rd(OFF_STATUS, 32'h3F000, 32'h3F000, "bypass groups");
        check("gateway bypass", 32'hF, {28'h0, comms_gateway[12:9]});
        {byp_l, byp_tr, byp_s, byp_st} <= 4'h0;
        ch_s <= 5'h0;
        ch_i <= 5'h0;
        settle(1'b0, 1'b0, "bypass off");
        $display("test logic done");
    endtask : t_logic

    // ====
    // main sequence and hang guard
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        t_regs;
        t_vote;
        t_bypass;
        t_faults;
        t_force;
        t_logic;
        test_done;
    end

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 40000) begin
            num_errors++;
            $display("mismatch timeout expected done seen running");
            test_done;
        end
    end
endmodule : tb
